/* File: rtl/scsi_command_sequencer.sv */
// programmable command sequencer core
// ---------------------------------------------------------------------
// Functional notes
// RL1: non-branch instructions retire every 50 ns; here two 5 ns clocks, so every 10 ns.
// RL2: 64 opcodes, each one 14-bit word, no multi-word forms.
// RL3: datapath and alu are eight bits wide.
// RL4: instruction memory holds 256 words addressed by pc.
// RL5: register file of 32 byte-wide general registers.
// RL6: five-entry return stack for calls and interrupt entry.
// RL7: operands by direct, indirect, absolute or immediate addressing.
// RL8: fetch uses its own memory, apart from data accesses.
// RL9: ordinary instruction takes two clocks, branch four clocks.
// RL10: two independent firmware interrupt sources redirect execution.
// RL11: firmware interrupt is taken without halting the running program.
// RL12: firmware vector stays writable while running; new value used later.
// RL13: two hardware interrupt lines, one with a four-bit vector.
// RL14: scsi interrupts pass to the cpu or are intercepted.
// RL15: intercepted interrupt handler chosen from scsi vector inputs.
// RL16: sequencer reaches its registers, fifo, dram and chip registers.
// RL17: cpu can reach every sequencer register over its local bus; here only the 32 general registers are readable and writable.
// RL18: after reset stays halted until cpu loads code and starts it.
// RL19: call or entry on a full stack raises overflow status.
// ---------------------------------------------------------------------
`timescale 1ns/1ps
`include "seq_defs.svh"
module scsi_command_sequencer #(
    parameter int IDEPTH = `SEQ_IDEPTH,
    parameter int NREG   = `SEQ_NREG,
    parameter int STK    = `SEQ_STK_DEPTH
)(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire seq_pkg::imem_wr_t     imem_wr_i,
    input  wire logic                  start_i,
    input  wire logic [7:0]            start_addr_i,
    input  wire logic                  firmware_irq_zero_i,
    input  wire logic                  firmware_irq_one_i,
    input  wire logic                  fw_vec_we_i,
    input  wire logic                  fw_vec_sel_i,
    input  wire logic [7:0]            fw_vec_i,
    input  wire logic                  hw_irq_a_i,
    input  wire logic                  hw_irq_b_i,
    input  wire logic [3:0]            hw_vec_i,
    input  wire logic                  hw_intercept_i,
    input  wire logic [7:0]            hw_vec_base_i,
    input  wire logic                  cpu_rf_we_i,
    input  wire logic [4:0]            cpu_rf_addr_i,
    input  wire logic [7:0]            cpu_rf_wdata_i,
    input  wire logic [7:0]            ext_rdata_i,
    input  wire logic                  ext_ack_i,
    output logic                       running_o,
    output logic                       stk_ovf_o,
    output logic                       cpu_hw_irq_o,
    output logic [7:0]                 cpu_rf_rdata_o,
    output logic [7:0]                 pc_o,
    output seq_pkg::ext_req_t          ext_o
);
    initial
    begin
        if (IDEPTH != `SEQ_IDEPTH || NREG != `SEQ_NREG || STK < 1
            || STK > 7)
            $error("unsupported sequencer geometry");
    end

    // -----------------------------------------------------------------
    // storage
    // -----------------------------------------------------------------
    logic [`SEQ_IW-1:0] imem [IDEPTH];                          // RL4 RL8
    logic [`SEQ_DW-1:0] rf   [NREG];                            // RL5
    logic [7:0]         stk  [STK];                             // RL6
    logic [7:0]         fw_vec_ff [2];

    seq_pkg::state_t    state_ff;
    logic [7:0]         pc_ff;
    logic [`SEQ_IW-1:0] ir_ff;
    logic [7:0]         acc_ff;
    logic               zero_ff;
    logic [2:0]         sp_ff;
    logic               br_wait_ff;
    logic               stk_ovf_ff;
    logic               irq0_pend_ff;
    logic               irq1_pend_ff;
    logic               hw_pend_ff;
    logic               in_isr_ff;
    logic               ext_wait_ff;
    logic [7:0]         ext_wr_addr_ff;
    seq_pkg::ext_req_t  ext_ff;
    logic [7:0]         cpu_rd_ff;

    // operand decode, shared by exec and store paths
    function automatic logic [5:0] f_op(input logic [`SEQ_IW-1:0] w);
        f_op = w[`SEQ_OP_MSB:`SEQ_OP_LSB];                      // RL2
    endfunction : f_op

    function automatic logic [7:0] f_arg(input logic [`SEQ_IW-1:0] w);
        f_arg = w[`SEQ_ARG_MSB:`SEQ_ARG_LSB];
    endfunction : f_arg

    function automatic logic f_is_rf(input logic [7:0] a);
        f_is_rf = (a <= `SEQ_RF_TOP);
    endfunction : f_is_rf

    logic [5:0] op;
    logic [7:0] arg;
    logic [7:0] rfa;
    logic [7:0] ind;
    logic [7:0] alu;
    logic       take_irq;
    logic [7:0] irq_vec;
    assign op  = f_op(ir_ff);
    assign arg = f_arg(ir_ff);
    assign rfa = rf[arg[4:0]];                                  // RL7
    assign ind = rf[rfa[4:0]];                                  // RL7

    // -----------------------------------------------------------------
    // alu
    // -----------------------------------------------------------------
    always_comb
    begin
        case (op)
            seq_pkg::OP_ADD:  alu = acc_ff + rfa;               // RL3
            seq_pkg::OP_SUB:  alu = acc_ff - rfa;
            seq_pkg::OP_AND:  alu = acc_ff & rfa;
            seq_pkg::OP_OR:   alu = acc_ff | rfa;
            seq_pkg::OP_XOR:  alu = acc_ff ^ rfa;
            seq_pkg::OP_ADDI: alu = acc_ff + arg;
            seq_pkg::OP_LDI:  alu = arg;                        // RL7
            seq_pkg::OP_LDD:  alu = rfa;                        // RL7
            seq_pkg::OP_LDX:  alu = ind;                        // RL7
            seq_pkg::OP_LDA:  alu = ext_rdata_i;                // RL7
            default:          alu = acc_ff;
        endcase
    end

    // interrupt priority: hardware first, then firmware zero, then one
    always_comb
    begin
        take_irq = !in_isr_ff && (hw_pend_ff || irq0_pend_ff
                                  || irq1_pend_ff);             // RL10
        if (hw_pend_ff)
            irq_vec = hw_vec_base_i + {4'h0, hw_vec_i};         // RL15 RL13
        else if (irq0_pend_ff)
            irq_vec = fw_vec_ff[0];                             // RL12
        else
            irq_vec = fw_vec_ff[1];
    end

    // -----------------------------------------------------------------
    // program load and cpu register access
    // -----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (imem_wr_i.we)
            imem[imem_wr_i.addr] <= imem_wr_i.data;             // RL18
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fw_vec_ff[0] <= 8'h00;
            fw_vec_ff[1] <= 8'h00;
        end
        else if (fw_vec_we_i)
            fw_vec_ff[fw_vec_sel_i] <= fw_vec_i;                // RL12
    end

    // cpu port wins a same-cycle collision with the program
    always_ff @(posedge clk_i)
    begin
        if (cpu_rf_we_i)
            rf[cpu_rf_addr_i] <= cpu_rf_wdata_i;                // RL17
        else if (state_ff == seq_pkg::ST_EXEC && f_is_rf(arg))
        begin
            if (op == seq_pkg::OP_STD)
                rf[arg[4:0]] <= acc_ff;                         // RL16
            else if (op == seq_pkg::OP_STX)
                rf[rfa[4:0]] <= acc_ff;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            cpu_rd_ff <= 8'h00;
        else
            cpu_rd_ff <= rf[cpu_rf_addr_i];                     // RL17
    end

    // -----------------------------------------------------------------
    // interrupt capture; a new event wins over its clear
    // -----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            irq0_pend_ff <= 1'b0;
            irq1_pend_ff <= 1'b0;
            hw_pend_ff   <= 1'b0;
            cpu_hw_irq_o <= 1'b0;
        end
        else
        begin
            irq0_pend_ff <= firmware_irq_zero_i || (irq0_pend_ff
                && !(state_ff == seq_pkg::ST_FETCH && take_irq
                     && !hw_pend_ff));                          // RL11
            irq1_pend_ff <= firmware_irq_one_i || (irq1_pend_ff
                && !(state_ff == seq_pkg::ST_FETCH && take_irq
                     && !hw_pend_ff && !irq0_pend_ff));
            hw_pend_ff <= (hw_intercept_i && hw_irq_a_i) || (hw_pend_ff
                && !(state_ff == seq_pkg::ST_FETCH && take_irq)); // RL14
            cpu_hw_irq_o <= hw_irq_b_i
                || (!hw_intercept_i && hw_irq_a_i);             // RL14 RL13
        end
    end

    // -----------------------------------------------------------------
    // sequencing: fetch, execute, two extra clocks on a taken branch
    // -----------------------------------------------------------------
    logic is_br;
    always_comb
    begin
        case (op)
            seq_pkg::OP_JMP, seq_pkg::OP_CALL, seq_pkg::OP_RET:
                is_br = 1'b1;
            seq_pkg::OP_JZ:  is_br = zero_ff;
            seq_pkg::OP_JNZ: is_br = !zero_ff;
            default:         is_br = 1'b0;
        endcase
    end

    logic ext_busy;
    assign ext_busy = (op == seq_pkg::OP_LDA || op == seq_pkg::OP_STA)
                      && !ext_ack_i;                            // RL16

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_ff   <= seq_pkg::ST_HALT;                     // RL18
            pc_ff      <= 8'h00;
            ir_ff      <= 14'h0000;
            acc_ff     <= 8'h00;
            zero_ff    <= 1'b1;
            sp_ff      <= 3'h0;
            br_wait_ff <= 1'b0;
            stk_ovf_ff <= 1'b0;
            in_isr_ff  <= 1'b0;
        end
        else
        begin
            case (state_ff)
                seq_pkg::ST_HALT:
                begin
                    if (start_i)
                    begin
                        pc_ff    <= start_addr_i;               // RL18
                        state_ff <= seq_pkg::ST_FETCH;
                    end
                end
                seq_pkg::ST_FETCH:
                begin
                    if (take_irq)
                    begin
                        // entry pushes the interrupted pc, then resumes
                        if (sp_ff == 3'(STK))
                            stk_ovf_ff <= 1'b1;                 // RL19
                        else
                        begin
                            stk[sp_ff] <= pc_ff;                // RL6
                            sp_ff      <= sp_ff + 3'h1;
                        end
                        pc_ff     <= irq_vec;                   // RL11
                        in_isr_ff <= 1'b1;
                        state_ff  <= seq_pkg::ST_BR;
                    end
                    else
                    begin
                        ir_ff    <= imem[pc_ff];                // RL8
                        pc_ff    <= pc_ff + 8'h01;
                        state_ff <= seq_pkg::ST_EXEC;           // RL9
                    end
                end
                seq_pkg::ST_EXEC:
                begin
                    if (!ext_busy)
                    begin
                        acc_ff   <= alu;                        // RL3
                        zero_ff  <= (alu == 8'h00);
                        state_ff <= is_br ? seq_pkg::ST_BR
                                          : seq_pkg::ST_FETCH;  // RL1 RL9
                        if (op == seq_pkg::OP_HALT)
                            state_ff <= seq_pkg::ST_HALT;
                        if (is_br)
                            pc_ff <= arg;
                        if (op == seq_pkg::OP_CALL)
                        begin
                            if (sp_ff == 3'(STK))
                                stk_ovf_ff <= 1'b1;             // RL19
                            else
                            begin
                                stk[sp_ff] <= pc_ff;            // RL6
                                sp_ff      <= sp_ff + 3'h1;
                            end
                        end
                        if (op == seq_pkg::OP_RET && sp_ff != 3'h0)
                        begin
                            pc_ff <= stk[sp_ff - 3'h1];         // RL6
                            sp_ff <= sp_ff - 3'h1;
                        end
                        if (op == seq_pkg::OP_ACKH)
                            in_isr_ff <= 1'b0;
                    end
                end
                seq_pkg::ST_BR:
                begin
                    // second refill clock brings a branch to four
                    br_wait_ff <= !br_wait_ff;                  // RL9
                    if (br_wait_ff)
                        state_ff <= seq_pkg::ST_FETCH;
                end
                default:
                    state_ff <= seq_pkg::ST_HALT;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // chip register, fifo and dram port
    // -----------------------------------------------------------------

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            ext_ff <= '0;
        else if (state_ff == seq_pkg::ST_EXEC && ext_busy)
        begin
            ext_ff.req   <= 1'b1;                               // RL16
            ext_ff.wr    <= (op == seq_pkg::OP_STA);
            ext_ff.addr  <= arg;
            ext_ff.wdata <= acc_ff;
        end
        else
            ext_ff <= '0;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            running_o      <= 1'b0;
            stk_ovf_o      <= 1'b0;
            cpu_rf_rdata_o <= 8'h00;
            pc_o           <= 8'h00;
        end
        else
        begin
            running_o      <= (state_ff != seq_pkg::ST_HALT);
            stk_ovf_o      <= stk_ovf_ff;                       // RL19
            cpu_rf_rdata_o <= cpu_rd_ff;
            pc_o           <= pc_ff;
        end
    end

    assign ext_o = ext_ff;

endmodule : scsi_command_sequencer

/* File: rtl/seq_defs.svh */
// constants for the command sequencer
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH
`define SEQ_IW          14
`define SEQ_DW          8
`define SEQ_IDEPTH      256
`define SEQ_NREG        32
`define SEQ_STK_DEPTH   5
`define SEQ_DDEPTH      256
`define SEQ_OP_MSB      13
`define SEQ_OP_LSB      8
`define SEQ_ARG_MSB     7
`define SEQ_ARG_LSB     0
`define SEQ_INSTR_NS    50
`define SEQ_CLK_NS      5
`define SEQ_RF_TOP      8'h1F
`define SEQ_CHIP_BASE   8'h20
`define SEQ_HW_VEC_MSB  3
`endif

/* File: rtl/seq_pkg.sv */
// types for the command sequencer
package seq_pkg;
    typedef enum logic [5:0]
    {
        OP_NOP  = 6'h00,
        OP_LDI  = 6'h01,
        OP_LDD  = 6'h02,
        OP_LDX  = 6'h03,
        OP_STD  = 6'h04,
        OP_STX  = 6'h05,
        OP_ADD  = 6'h06,
        OP_SUB  = 6'h07,
        OP_AND  = 6'h08,
        OP_OR   = 6'h09,
        OP_XOR  = 6'h0A,
        OP_ADDI = 6'h0B,
        OP_JMP  = 6'h0C,
        OP_JZ   = 6'h0D,
        OP_JNZ  = 6'h0E,
        OP_CALL = 6'h0F,
        OP_RET  = 6'h10,
        OP_HALT = 6'h11,
        OP_LDA  = 6'h12,
        OP_STA  = 6'h13,
        OP_MOV  = 6'h14,
        OP_ACKH = 6'h15
    } opcode_t;

    typedef enum logic [3:0]
    {
        ST_HALT  = 4'b0001,
        ST_FETCH = 4'b0010,
        ST_EXEC  = 4'b0100,
        ST_BR    = 4'b1000
    } state_t;

    typedef struct packed
    {
        logic       req;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ext_req_t;

    typedef struct packed
    {
        logic       we;
        logic [7:0] addr;
        logic [13:0] data;
    } imem_wr_t;
endpackage : seq_pkg

/* File: tb/scsi_command_sequencer_sva.sv */
// concurrent checks on the command sequencer ports
`timescale 1ns/1ps
module scsi_command_sequencer_sva (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              start_i,
    input wire logic              hw_irq_a_i,
    input wire logic              hw_irq_b_i,
    input wire logic              hw_intercept_i,
    input wire logic              cpu_rf_we_i,
    input wire logic [4:0]        cpu_rf_addr_i,
    input wire logic [7:0]        cpu_rf_wdata_i,
    input wire logic              ext_ack_i,
    input wire logic              running_o,
    input wire logic              stk_ovf_o,
    input wire logic              cpu_hw_irq_o,
    input wire logic [7:0]        cpu_rf_rdata_o,
    input wire logic [7:0]        pc_o,
    input wire seq_pkg::ext_req_t ext_o
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_RUN_CAUSE: assert property ($rose(running_o) |->
        $past(start_i) || $past(start_i, 2))
        else $error("sequencer left halt without a start");
    AST_OVF_STICKY: assert property (stk_ovf_o |=> stk_ovf_o)
        else $error("overflow status dropped before reset");
    AST_PASS_A: assert property (hw_irq_a_i && !hw_intercept_i
        |=> cpu_hw_irq_o) else $error("line a not passed to cpu");
    AST_PASS_B: assert property (hw_irq_b_i |=> cpu_hw_irq_o)
        else $error("line b not passed to cpu");
    AST_NO_LEAK: assert property (cpu_hw_irq_o |-> $past(hw_irq_b_i)
        || $past(hw_irq_a_i && !hw_intercept_i))
        else $error("intercepted interrupt reached the cpu");
    AST_RF_READ: assert property ($past(cpu_rf_we_i, 3)
        && !$past(cpu_rf_we_i, 2) && !$past(cpu_rf_we_i)
        && $past(cpu_rf_addr_i, 3) == cpu_rf_addr_i
        && $past(cpu_rf_addr_i, 2) == cpu_rf_addr_i
        && $past(cpu_rf_addr_i) == cpu_rf_addr_i
        && !running_o && !$past(running_o, 3)
        |-> cpu_rf_rdata_o == $past(cpu_rf_wdata_i, 3))
        else $error("register file read back wrong");
    AST_EXT_HOLD: assert property (ext_o.req && !ext_ack_i |=>
        ext_o.req && $stable(ext_o.addr) && $stable(ext_o.wr))
        else $error("access changed before its answer");
    AST_HALT_QUIET: assert property (!running_o |-> !ext_o.req)
        else $error("access while halted");
    AST_PC_SPACING: assert property (running_o && $past(running_o)
        && pc_o == $past(pc_o) + 8'h01 |=> pc_o != $past(pc_o) + 8'h01)
        else $error("instruction shorter than two clocks");
endmodule : scsi_command_sequencer_sva

bind scsi_command_sequencer scsi_command_sequencer_sva u_sva (.clk_i,
    .rst_i, .start_i, .hw_irq_a_i, .hw_irq_b_i, .hw_intercept_i,
    .cpu_rf_we_i, .cpu_rf_addr_i, .cpu_rf_wdata_i, .ext_ack_i, .running_o,
    .stk_ovf_o, .cpu_hw_irq_o, .cpu_rf_rdata_o, .pc_o, .ext_o);

/* File: tb/scsi_chip_space_model.sv */
// far-side model of chip registers, fifo and buffer space
`timescale 1ns/1ps
module scsi_chip_space_model (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire seq_pkg::ext_req_t ext_i,
    input  wire logic [3:0]        delay_i,
    output logic                   ack_o,
    output logic [7:0]             rdata_o
);
    // ------------------------------------------------------------
    // chip space
    // ------------------------------------------------------------
    logic [7:0] mem_ff [256];
    logic [3:0] wait_ff;

    // the cycle after an ack is skipped: the request is registered
    // and may still show high for one more cycle
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ack_o   <= 1'b0;
            wait_ff <= 4'h0;
            rdata_o <= 8'h00;
        end
        else if (ext_i.req && !ack_o && wait_ff >= delay_i)
        begin
            ack_o   <= 1'b1;
            wait_ff <= 4'h0;
            rdata_o <= mem_ff[ext_i.addr];
            if (ext_i.wr)
                mem_ff[ext_i.addr] <= ext_i.wdata;
        end
        else
        begin
            ack_o   <= 1'b0;
            wait_ff <= (ext_i.req && !ack_o) ? wait_ff + 4'h1 : 4'h0;
            rdata_o <= ~rdata_o; // no stale data once released
        end
    end
endmodule : scsi_chip_space_model

/* File: tb/scsi_command_sequencer_test.sv */
// self-checking bench for the command sequencer
`timescale 1ns/1ps
module scsi_command_sequencer_test;
    logic clk_i, rst_i, start_i, firmware_irq_zero_i, firmware_irq_one_i;
    logic fw_vec_we_i, fw_vec_sel_i, hw_irq_a_i, hw_irq_b_i;
    logic hw_intercept_i, cpu_rf_we_i, ext_ack_i;
    logic running_o, stk_ovf_o, cpu_hw_irq_o;
    logic [7:0] start_addr_i, fw_vec_i, hw_vec_base_i, cpu_rf_wdata_i;
    logic [7:0] ext_rdata_i, cpu_rf_rdata_o, pc_o;
    logic [4:0] cpu_rf_addr_i;
    logic [3:0] hw_vec_i, dly;
    seq_pkg::imem_wr_t imem_wr_i;
    seq_pkg::ext_req_t ext_o;
    int n_fail, comparisons, n;

    scsi_command_sequencer uut (.clk_i, .rst_i, .imem_wr_i, .start_i,
        .start_addr_i, .firmware_irq_zero_i, .firmware_irq_one_i,
        .fw_vec_we_i, .fw_vec_sel_i, .fw_vec_i, .hw_irq_a_i, .hw_irq_b_i,
        .hw_vec_i, .hw_intercept_i, .hw_vec_base_i, .cpu_rf_we_i,
        .cpu_rf_addr_i, .cpu_rf_wdata_i, .ext_rdata_i, .ext_ack_i,
        .running_o, .stk_ovf_o, .cpu_hw_irq_o, .cpu_rf_rdata_o, .pc_o,
        .ext_o);
    scsi_chip_space_model part (.clk_i, .rst_i, .ext_i(ext_o),
        .delay_i(dly), .ack_o(ext_ack_i), .rdata_o(ext_rdata_i));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] b(input logic x);
        return {7'h00, x};
    endfunction : b

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    task automatic reset_dut();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask : reset_dut

    task automatic put(input logic [7:0] a, input seq_pkg::opcode_t op,
                       input logic [7:0] arg);
        @(posedge clk_i);
        imem_wr_i <= '{we: 1'b1, addr: a, data: {op, arg}};
    endtask : put

    // start is a one-cycle pulse; imem writes end with it
    task automatic go(input logic [7:0] a);
        @(posedge clk_i);
        imem_wr_i.we <= 1'b0;
        start_i      <= 1'b1;
        start_addr_i <= a;
        @(posedge clk_i);
        start_i      <= 1'b0;
    endtask : go

    task automatic wait_pc(input logic [7:0] t);
        for (n = 0; pc_o !== t && n < 64; n++) @(negedge clk_i);
        check(pc_o, t);
    endtask : wait_pc

    task automatic wait_halt();
        repeat (4) @(negedge clk_i);
        for (int i = 0; running_o !== 1'b0 && i < 300; i++) @(negedge clk_i);
    endtask : wait_halt

    task automatic rf_wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cpu_rf_we_i    <= 1'b1;
        cpu_rf_addr_i  <= a;
        cpu_rf_wdata_i <= d;
        @(posedge clk_i);
        cpu_rf_we_i    <= 1'b0;
    endtask : rf_wr

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_idle();
        @(negedge clk_i);
        check(pc_o, 8'h00);
        check(b(ext_o.req), 8'h00);
        repeat (20) @(negedge clk_i);
        check(b(running_o), 8'h00);
    endtask : t_idle

    task automatic t_rf();
        rf_wr(5'h00, 8'hA5);
        rf_wr(5'h1F, 8'h5A);
        repeat (3) @(negedge clk_i);
        check(cpu_rf_rdata_o, 8'h5A);
        @(posedge clk_i);
        cpu_rf_addr_i <= 5'h00;
        repeat (3) @(negedge clk_i);
        check(cpu_rf_rdata_o, 8'hA5);
    endtask : t_rf

    // nop loop with a branch; handlers at 30, 34, 38 and 3C ack, return
    task automatic t_rate();
        for (int i = 0; i < 8; i++) put(8'h10 + 8'(i), seq_pkg::OP_NOP, 8'h00);
        put(8'h18, seq_pkg::OP_JMP, 8'h10);
        for (int i = 0; i < 8; i++)
            put(8'h30 + 8'(2 * i - i % 2),
                i % 2 ? seq_pkg::OP_RET : seq_pkg::OP_ACKH, 8'h00);
        go(8'h10);
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        check(b(running_o), 8'h01);
        wait_pc(8'h11);
        wait_pc(8'h15);
        check(8'(n), 8'h08);
        wait_pc(8'h19);
        wait_pc(8'h11);
        check(8'(n), 8'h04);
        go(8'h80);
        repeat (20) @(negedge clk_i);
        check(b(pc_o <= 8'h19), 8'h01);
    endtask : t_rate

    task automatic t_fw();
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk_i);
            fw_vec_we_i  <= 1'b1;
            fw_vec_sel_i <= (i == 2);
            fw_vec_i     <= 8'h30 + 8'(4 * i);
            @(posedge clk_i);
            fw_vec_we_i  <= 1'b0;
            firmware_irq_zero_i <= (i != 2);
            firmware_irq_one_i  <= (i == 2);
            @(posedge clk_i);
            firmware_irq_zero_i <= 1'b0;
            firmware_irq_one_i  <= 1'b0;
            wait_pc(8'h30 + 8'(4 * i));
            wait_pc(8'h10);
            check(b(running_o), 8'h01);
        end
    endtask : t_fw

    task automatic t_hw();
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk_i);
            hw_intercept_i <= (i == 1);
            hw_irq_a_i     <= 1'b1;
            hw_vec_i       <= 4'h5;
            hw_vec_base_i  <= 8'h37;
            @(posedge clk_i);
            hw_irq_a_i     <= 1'b0;
            @(negedge clk_i);
            check(b(cpu_hw_irq_o), b(i == 0));
        end
        wait_pc(8'h3C);
        @(posedge clk_i);
        hw_irq_b_i <= 1'b1;
        @(posedge clk_i);
        hw_irq_b_i <= 1'b0;
        @(negedge clk_i);
        check(b(cpu_hw_irq_o), 8'h01);
    endtask : t_hw

    // store, load back and store again through the far side
    task automatic t_ext();
        for (int k = 0; k < 2; k++)
        begin
            reset_dut();
            dly <= 4'(3 * k);
            put(8'h50, seq_pkg::OP_LDI, 8'h3C + 8'(k));
            put(8'h51, seq_pkg::OP_STA, 8'h26);
            put(8'h52, seq_pkg::OP_LDI, 8'h00);
            put(8'h53, seq_pkg::OP_LDA, 8'h26);
            put(8'h54, seq_pkg::OP_ADDI, 8'h01);
            put(8'h55, seq_pkg::OP_STA, 8'h27);
            put(8'h56, seq_pkg::OP_HALT, 8'h00);
            go(8'h50);
            wait_halt();
            check(part.mem_ff[8'h27], 8'h3D + 8'(k));
            check(b(running_o), 8'h00);
        end
    endtask : t_ext

    task automatic t_ovf();
        reset_dut();
        for (int i = 0; i < 6; i++)
            put(8'h60 + 8'(i), seq_pkg::OP_CALL, 8'h61 + 8'(i));
        put(8'h66, seq_pkg::OP_HALT, 8'h00);
        go(8'h60);
        wait_pc(8'h65);
        check(b(stk_ovf_o), 8'h00);
        wait_halt();
        check(b(stk_ovf_o), 8'h01);
    endtask : t_ovf

    // ------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        conclude();
    end

    initial
    begin
        rst_i = 1'b1;
        {start_i, firmware_irq_zero_i, firmware_irq_one_i} = 3'h0;
        {fw_vec_we_i, fw_vec_sel_i, hw_irq_a_i, hw_irq_b_i} = 4'h0;
        {hw_intercept_i, cpu_rf_we_i} = 2'h0;
        {start_addr_i, fw_vec_i, hw_vec_base_i, cpu_rf_wdata_i} = 32'h0;
        {cpu_rf_addr_i, hw_vec_i, dly} = 13'h0;
        imem_wr_i = '0;
        n_fail = 0;
        comparisons = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_idle();
        t_rf();
        t_rate();
        t_fw();
        t_hw();
        t_ext();
        t_ovf();
        conclude();
    end
endmodule : scsi_command_sequencer_test
